// ===== hw/rtc_ctrl_pkg.sv
// Shared constants and types for the clock trim, shadow and alarm control.
// Assumes an 8-bit register port with 16-bit byte addresses.
package rtc_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [15:0] OFS_ANALOG_TRIM = 16'h2504;
  localparam logic [15:0] OFS_CTRL_STATUS = 16'h2890;
  localparam logic [15:0] OFS_SUBSECOND = 16'h2892;
  localparam logic [15:0] OFS_SHADOW_SEC = 16'h2893;
  localparam logic [15:0] OFS_SHADOW_MIN = 16'h2894;
  localparam logic [15:0] OFS_SHADOW_HR = 16'h2895;
  localparam logic [15:0] OFS_COARSE_HIGH = 16'h289B;
  localparam logic [15:0] OFS_COARSE_MID = 16'h289C;
  localparam logic [15:0] OFS_COARSE_LOW_FINE = 16'h289D;
  localparam logic [15:0] OFS_TARGET_MIN = 16'h289E;
  localparam logic [15:0] OFS_TARGET_HOUR = 16'h289F;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h28A0;
  localparam logic [15:0] OFS_IRQ_CLEAR = 16'h28A1;
  localparam logic [15:0] OFS_IRQ_ENABLE = 16'h28A2;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_COUNT_FAIL = 4;
  localparam int BIT_READ_FREEZE = 6;
  localparam int BIT_WRITE_FREEZE = 7;
  localparam int IRQ_BIT_ALARM = 0;
  localparam int IRQ_BIT_FAIL = 1;
  localparam int IRQ_WIDTH = 2;

  // ----------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [6:0] RST_ANALOG_TRIM = 7'h40;
  localparam logic [2:0] RST_COARSE_HIGH = 3'h4;
  localparam logic [16:0] RST_COARSE =
    {RST_COARSE_HIGH, 14'h0};
  localparam logic [1:0] RST_FINE = 2'h0;
  localparam logic [16:0] COARSE_LEGAL_MIN = 17'h0FFBF;
  localparam logic [16:0] COARSE_LEGAL_MAX = 17'h10040;
  localparam logic [7:0] SUBSEC_TOP = 8'h7F;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } time_t;

endpackage : rtc_ctrl_pkg

// ===== hw/rtc_subsec_count.sv
// Sub-second countdown from 127 to 0 in steps of 1/128 second.
// Assumes tick_128 is a one-cycle pulse on core_clk at 128 Hz.
`timescale 1ns/100ps
module rtc_subsec_count
  import rtc_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic tick_128,
  output logic [7:0] remaining,
  output logic second_pulse
);

  logic [7:0] rem_q;
  logic [7:0] rem_d;
  logic sec_q;
  wire wrap = (rem_q == 8'h00);

  assign rem_d = wrap ? SUBSEC_TOP : rem_q - 8'h01;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rem_q <= SUBSEC_TOP;
      sec_q <= 1'b0;
    end else if (ce) begin
      sec_q <= tick_128 & wrap;
      if (tick_128) begin
        rem_q <= rem_d;
      end
    end
  end

  assign remaining = rem_q;
  assign second_pulse = sec_q;

endmodule : rtc_subsec_count

// ===== hw/rtc_alarm_match.sv
// Detects the moment the running time becomes equal to the alarm target.
// Assumes the counters change on core_clk; no resynchronising needed.
`timescale 1ns/100ps
module rtc_alarm_match
  import rtc_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [5:0] minute,
  input wire logic [4:0] hour,
  input wire logic [5:0] target_minute,
  input wire logic [4:0] target_hour,
  output logic match_pulse
);

  logic eq_q;
  logic pulse_q;
  wire eq_now = (minute == target_minute) && (hour == target_hour);

  // Equality held out of reset does not fire; only a new match does.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eq_q <= 1'b1;
      pulse_q <= 1'b0;
    end else if (ce) begin
      eq_q <= eq_now;
      pulse_q <= eq_now & ~eq_q;
    end
  end

  assign match_pulse = pulse_q;

endmodule : rtc_alarm_match

// ===== hw/rtc_trim_shadow_alarm_control.sv
// Register file and control for clock trim, rate adjust, shadow and alarm.
// Assumes time counters, count-error and wake pulses run on core_clk.
//
// Summary of operation
// - Seven-bit analog trim, resets to 0x40.
// - Counter error sets the failure flag.
// - Writing zero clears failure; reset and wake clear.
// - Coarse and fine fields form 19-bit adjust.
// - Coarse top bits reset to four, rest zero.
// - Read freeze stops shadow updates.
// - Freeze bit reads actual shadow state.
// - Read-only sub-second remaining, 1/128 second units.
// - Six-bit target minute, resets to zero.
// - Alarm interrupt when minute and hour match.
// - Write freeze holds shadow for processor writes.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module rtc_trim_shadow_alarm_control
  import rtc_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  input wire logic count_error,
  input wire logic wake,
  input wire logic tick_128,
  input wire time_t time_now,
  output logic [6:0] analog_trim,
  output logic [18:0] rate_adjust,
  output time_t shadow_time,
  output logic shadow_write_hold,
  output logic second_pulse,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire wr_trim = req.wr && (req.addr == OFS_ANALOG_TRIM);
  wire wr_ctrl = req.wr && (req.addr == OFS_CTRL_STATUS);
  wire wr_chigh = req.wr && (req.addr == OFS_COARSE_HIGH);
  wire wr_cmid = req.wr && (req.addr == OFS_COARSE_MID);
  wire wr_clow = req.wr && (req.addr == OFS_COARSE_LOW_FINE);
  wire wr_tmin = req.wr && (req.addr == OFS_TARGET_MIN);
  wire wr_thour = req.wr && (req.addr == OFS_TARGET_HOUR);
  wire wr_iclr = req.wr && (req.addr == OFS_IRQ_CLEAR);
  wire wr_ien = req.wr && (req.addr == OFS_IRQ_ENABLE);
  wire wr_ssec = req.wr && (req.addr == OFS_SHADOW_SEC);
  wire wr_smin = req.wr && (req.addr == OFS_SHADOW_MIN);
  wire wr_shr = req.wr && (req.addr == OFS_SHADOW_HR);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [6:0] trim_q;
  logic fail_q;
  logic rd_freeze_q;
  logic wr_freeze_q;
  logic frozen_q;
  logic [16:0] coarse_q;
  logic [1:0] fine_q;
  logic [5:0] tmin_q;
  logic [4:0] thour_q;
  logic [IRQ_WIDTH-1:0] ista_q;
  logic [IRQ_WIDTH-1:0] ien_q;
  time_t shadow_q;
  time_t shadow_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] subsec;
  logic alarm_pulse;
  logic [IRQ_WIDTH-1:0] ev;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  rtc_subsec_count u_subsec (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .tick_128(tick_128),
    .remaining(subsec),
    .second_pulse(second_pulse)
  );

  rtc_alarm_match u_alarm (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .minute(time_now.minute),
    .hour(time_now.hour),
    .target_minute(tmin_q),
    .target_hour(thour_q),
    .match_pulse(alarm_pulse)
  );

  // ----------------------------------------------------------------------
  // Failure flag
  // ----------------------------------------------------------------------
  // A new error in the same cycle as a zero write keeps the flag set.
  wire fail_clr = wr_ctrl && !req.wdata[BIT_COUNT_FAIL];
  wire fail_d = count_error | (fail_q & ~fail_clr);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fail_q <= 1'b0;
    end else if (ce) begin
      fail_q <= wake ? 1'b0 : fail_d;
    end
  end

  // ----------------------------------------------------------------------
  // Trim, rate adjust and alarm target
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trim_q <= RST_ANALOG_TRIM;
      tmin_q <= 6'h00;
      thour_q <= 5'h00;
    end else if (ce) begin
      if (wr_trim) trim_q <= req.wdata[6:0];
      if (wr_tmin) tmin_q <= req.wdata[5:0];
      if (wr_thour) thour_q <= req.wdata[4:0];
    end
  end

  // Out-of-range coarse values are stored as written; the range is
  // the programmer's duty and clamping would hide the mistake.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      coarse_q <= RST_COARSE;
      fine_q <= RST_FINE;
    end else if (ce) begin
      if (wake) begin
        coarse_q <= RST_COARSE;
        fine_q <= RST_FINE;
      end else begin
        if (wr_chigh) coarse_q[16:14] <= req.wdata[2:0];
        if (wr_cmid) coarse_q[13:6] <= req.wdata;
        if (wr_clow) coarse_q[5:0] <= req.wdata[7:2];
        if (wr_clow) fine_q <= req.wdata[1:0];
      end
    end
  end

  assign rate_adjust = {coarse_q, fine_q};
  assign analog_trim = trim_q;

  // ----------------------------------------------------------------------
  // Shadow copy
  // ----------------------------------------------------------------------
  // The frozen status trails the request by one cycle so that a read
  // showing 1 guarantees the copy has really stopped moving.
  always_comb begin
    shadow_d = shadow_q;
    if (!(rd_freeze_q || wr_freeze_q)) begin
      shadow_d = time_now;
    end else if (wr_freeze_q) begin
      if (wr_ssec) shadow_d.second = req.wdata[5:0];
      if (wr_smin) shadow_d.minute = req.wdata[5:0];
      if (wr_shr) shadow_d.hour = req.wdata[4:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_freeze_q <= 1'b0;
      wr_freeze_q <= 1'b0;
      frozen_q <= 1'b0;
      shadow_q <= '0;
    end else if (ce) begin
      if (wr_ctrl) begin
        rd_freeze_q <= req.wdata[BIT_READ_FREEZE];
        wr_freeze_q <= req.wdata[BIT_WRITE_FREEZE];
      end
      frozen_q <= rd_freeze_q | wr_freeze_q;
      shadow_q <= shadow_d;
    end
  end

  assign shadow_time = shadow_q;
  assign shadow_write_hold = wr_freeze_q;

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  assign ev[IRQ_BIT_ALARM] = alarm_pulse;
  assign ev[IRQ_BIT_FAIL] = count_error;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_WIDTH; gi++) begin : g_irq
      wire clr = wr_iclr && req.wdata[gi];
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          ista_q[gi] <= 1'b0;
          ien_q[gi] <= 1'b0;
        end else if (ce) begin
          ista_q[gi] <= ev[gi] | (ista_q[gi] & ~clr);
          if (wr_ien) ien_q[gi] <= req.wdata[gi];
        end
      end
    end
  endgenerate

  assign irq = |(ista_q & ien_q);

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  wire [7:0] ctrl_rd = {wr_freeze_q, frozen_q, 1'b0, fail_q, 4'h0};

  always_comb begin
    rdata_d = 8'h00;
    unique case (req.addr)
      OFS_ANALOG_TRIM: rdata_d = {1'b0, trim_q};
      OFS_CTRL_STATUS: rdata_d = ctrl_rd;
      OFS_SUBSECOND: rdata_d = subsec;
      OFS_SHADOW_SEC: rdata_d = {2'h0, shadow_q.second};
      OFS_SHADOW_MIN: rdata_d = {2'h0, shadow_q.minute};
      OFS_SHADOW_HR: rdata_d = {3'h0, shadow_q.hour};
      OFS_COARSE_HIGH: rdata_d = {5'h00, coarse_q[16:14]};
      OFS_COARSE_MID: rdata_d = coarse_q[13:6];
      OFS_COARSE_LOW_FINE: rdata_d = {coarse_q[5:0], fine_q};
      OFS_TARGET_MIN: rdata_d = {2'h0, tmin_q};
      OFS_TARGET_HOUR: rdata_d = {3'h0, thour_q};
      OFS_IRQ_STATUS: rdata_d = {6'h00, ista_q};
      OFS_IRQ_ENABLE: rdata_d = {6'h00, ien_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      rdata_q <= req.rd ? rdata_d : 8'h00;
    end
  end

  assign rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_fail_sets: assert property (
    (ce && count_error && !wake) |=> fail_q)
    else $error("count error did not set failure flag");

  a_fail_zero_clear: assert property (
    (ce && fail_q && wr_ctrl && !req.wdata[BIT_COUNT_FAIL]
     && !count_error) |=> !fail_q)
    else $error("zero write did not clear failure flag");

  a_fail_no_fake: assert property (
    (ce && !fail_q && !count_error) |=> !fail_q)
    else $error("failure flag rose without a count error");

  a_trim_reset_val: assert property (
    $rose(nrst) |-> (analog_trim == 7'h40))
    else $error("analog trim reset value wrong");

  a_rate_concat: assert property (
    (ce && wr_clow && !wake) |=>
      (rate_adjust[7:0] == $past(req.wdata)))
    else $error("rate adjust low byte not placed");

  a_wake_coarse: assert property (
    (ce && wake) |=> (rate_adjust == 19'h40000))
    else $error("wake did not restore rate adjust");

  a_shadow_holds: assert property (
    (ce && rd_freeze_q && !wr_freeze_q) |=> $stable(shadow_time))
    else $error("shadow moved while read frozen");

  a_frozen_reports: assert property (
    (ce && req.rd && req.addr == OFS_CTRL_STATUS) |=>
      (rdata[BIT_READ_FREEZE] == $past(frozen_q)))
    else $error("freeze bit does not report shadow state");

  a_subsec_range: assert property (
    (ce && tick_128 && subsec == 8'h00) |=> (subsec == SUBSEC_TOP))
    else $error("sub-second countdown did not reload");

  a_tmin_write: assert property (
    (ce && wr_tmin) |=> (tmin_q == $past(req.wdata[5:0])))
    else $error("target minute not stored");

  a_alarm_irq: assert property (
    (ce && alarm_pulse && ien_q[IRQ_BIT_ALARM] && !wr_ien) |=> irq)
    else $error("alarm match did not raise interrupt");

  a_write_hold: assert property (
    (ce && wr_ctrl && req.wdata[BIT_WRITE_FREEZE]) ##1 ce |=> frozen_q)
    else $error("write freeze did not freeze shadow");

  a_fail_wake_clear: assert property (
    (ce && wake) |=> !fail_q)
    else $error("wake did not clear failure flag");

  a_shadow_follows: assert property (
    (ce && !rd_freeze_q && !wr_freeze_q) |=>
      (shadow_time == $past(time_now)))
    else $error("shadow did not follow live time");

  a_subsec_step: assert property (
    (ce && tick_128 && subsec != 8'h00) |=>
      (subsec == $past(subsec) - 8'h01))
    else $error("sub-second countdown did not step");

  a_alarm_status: assert property (
    (ce && alarm_pulse) |=> ista_q[IRQ_BIT_ALARM])
    else $error("alarm match did not set status");

  // A pending event must survive until software clears it.
  a_status_sticky: assert property (
    (ce && ista_q[IRQ_BIT_FAIL]
     && !(wr_iclr && req.wdata[IRQ_BIT_FAIL])) |=> ista_q[IRQ_BIT_FAIL])
    else $error("failure status bit lost without a clear");

  a_rdata_idle: assert property (
    (ce && !req.rd) |=> (rdata == 8'h00))
    else $error("read data not zero outside a read");

  // With the enable low nothing may move, the read data included.
  a_ce_freeze: assert property (
    !ce |=> ($stable(analog_trim) && $stable(rate_adjust)
      && $stable(shadow_time) && $stable(rdata) && $stable(irq)))
    else $error("state moved while clock enable was low");

  c_alarm_fires: cover property (ce && alarm_pulse);
  c_fail_then_clear: cover property (fail_q ##[1:20] !fail_q);
  c_read_frozen: cover property (
    req.rd && req.addr == OFS_CTRL_STATUS && frozen_q);
  c_shadow_write: cover property (ce && wr_freeze_q && wr_smin);
  c_second_wrap: cover property (ce && second_pulse);

endmodule : rtc_trim_shadow_alarm_control

// ===== bench/tb.sv
// Self-checking bench for the clock trim, shadow and alarm control block.
// Assumes one core clock and a register port answering reads next cycle.
`timescale 1ns/100ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t %s: got %h expected %h", $time, m, g, e); end end
module tb
  import rtc_ctrl_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and design under test
  // ----------------------------------------------------------------------
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic count_error = 1'b0;
  logic wake = 1'b0;
  logic tick_128 = 1'b0;
  reg_req_t req = '0;
  time_t time_now = '0;
  logic [7:0] rdata;
  logic [6:0] analog_trim;
  logic [18:0] rate_adjust;
  time_t shadow_time;
  logic shadow_write_hold;
  logic second_pulse;
  logic irq;
  int n_fail = 0;
  int n_checks = 0;
  int n_sec = 0;
  logic [31:0] seed = 32'hCE09;
  logic [31:0] r;
  logic [16:0] c;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  time_t t0;

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  rtc_trim_shadow_alarm_control dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .req(req),
    .rdata(rdata),
    .count_error(count_error),
    .wake(wake),
    .tick_128(tick_128),
    .time_now(time_now),
    .analog_trim(analog_trim),
    .rate_adjust(rate_adjust),
    .shadow_time(shadow_time),
    .shadow_write_hold(shadow_write_hold),
    .second_pulse(second_pulse),
    .irq(irq)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Hours stay below 16 so the alarm target of hour 17 never matches early.
  function automatic time_t rtime();
    logic [31:0] x;
    x = rnd();
    return '{hour: {1'b0, x[3:0]}, minute: {1'b0, x[8:4]} + 6'h01,
      second: {1'b0, x[13:9]}};
  endfunction : rtime

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    req.rd <= 1'b0;
  endtask : rd

  task automatic fire(input logic e, input logic w, input logic t);
    @(posedge core_clk);
    count_error <= e;
    wake <= w;
    tick_128 <= t;
    @(posedge core_clk);
    count_error <= 1'b0;
    wake <= 1'b0;
    tick_128 <= 1'b0;
  endtask : fire

  task automatic summarize();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------------
  // Output watchers
  // ----------------------------------------------------------------------
  // Read data is judged mid-cycle, away from the edge that launches it.
  always @(posedge core_clk) begin
    rd_pend <= req.rd;
  end

  always @(negedge core_clk) begin
    if (second_pulse === 1'b1) begin
      n_sec++;
    end
    if (rd_pend) begin
      `CHK(rdata, exp_q[0], "read data")
      void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    summarize();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    settle(1);
    `CHK(analog_trim, 7'h40, "trim reset")
    `CHK(rate_adjust, 19'h40000, "rate reset")
    rd(OFS_ANALOG_TRIM, 8'h40);
    rd(OFS_COARSE_HIGH, 8'h04);
    rd(OFS_COARSE_MID, 8'h00);
    rd(OFS_COARSE_LOW_FINE, 8'h00);
    rd(OFS_TARGET_MIN, 8'h00);
    rd(OFS_CTRL_STATUS, 8'h00);
    rd(16'h1234, 8'h00);
    r = rnd();
    wr(OFS_ANALOG_TRIM, {1'b0, r[6:0]});
    settle(0);
    `CHK(analog_trim, r[6:0], "trim write")
    rd(OFS_ANALOG_TRIM, {1'b0, r[6:0]});
    ce <= 1'b0;
    wr(OFS_ANALOG_TRIM, {1'b0, ~r[6:0]});
    settle(0);
    `CHK(analog_trim, r[6:0], "trim held by enable")
    @(posedge core_clk);
    ce <= 1'b1;
    rd(OFS_ANALOG_TRIM, {1'b0, r[6:0]});
    for (int i = 0; i < 2; i++) begin
      c = (i == 0) ? 17'h0FFBF : 17'h10040;
      r = rnd();
      wr(OFS_COARSE_HIGH, {5'h00, c[16:14]});
      wr(OFS_COARSE_MID, c[13:6]);
      wr(OFS_COARSE_LOW_FINE, {c[5:0], r[1:0]});
      settle(0);
      `CHK(rate_adjust, {c, r[1:0]}, "rate adjust")
      rd(OFS_COARSE_LOW_FINE, {c[5:0], r[1:0]});
    end
    fire(1'b1, 1'b0, 1'b0);
    rd(OFS_CTRL_STATUS, 8'h10);
    wr(OFS_CTRL_STATUS, 8'h10);
    rd(OFS_CTRL_STATUS, 8'h10);
    wr(OFS_CTRL_STATUS, 8'h00);
    rd(OFS_CTRL_STATUS, 8'h00);
    wr(OFS_CTRL_STATUS, 8'h10);
    rd(OFS_CTRL_STATUS, 8'h00);
    fire(1'b1, 1'b0, 1'b0);
    fire(1'b0, 1'b1, 1'b0);
    settle(0);
    `CHK(rate_adjust, 19'h40000, "wake rate")
    rd(OFS_CTRL_STATUS, 8'h00);
    @(posedge core_clk);
    time_now <= rtime();
    settle(2);
    `CHK(shadow_time, time_now, "shadow follow")
    wr(OFS_CTRL_STATUS, 8'h40);
    t0 = time_now;
    @(posedge core_clk);
    time_now <= rtime();
    settle(3);
    `CHK(shadow_time, t0, "shadow frozen")
    rd(OFS_CTRL_STATUS, 8'h40);
    rd(OFS_SHADOW_MIN, {2'b00, t0.minute});
    wr(OFS_CTRL_STATUS, 8'h00);
    settle(3);
    `CHK(shadow_time, time_now, "shadow resume")
    rd(OFS_CTRL_STATUS, 8'h00);
    wr(OFS_CTRL_STATUS, 8'h80);
    t0 = time_now;
    @(posedge core_clk);
    time_now <= rtime();
    r = rnd();
    wr(OFS_SHADOW_MIN, {2'b00, r[5:0]});
    settle(1);
    `CHK(shadow_write_hold, 1'b1, "write hold")
    `CHK(shadow_time.minute, r[5:0], "shadow write")
    `CHK(shadow_time.hour, t0.hour, "shadow static")
    wr(OFS_CTRL_STATUS, 8'h00);
    repeat (5) fire(1'b0, 1'b0, 1'b1);
    rd(OFS_SUBSECOND, 8'h7A);
    n_sec = 0;
    repeat (123) fire(1'b0, 1'b0, 1'b1);
    settle(1);
    `CHK(n_sec, 1, "second pulse")
    rd(OFS_SUBSECOND, 8'h7F);
    wr(OFS_IRQ_CLEAR, 8'h03);
    wr(OFS_IRQ_ENABLE, 8'h03);
    r = rnd();
    t0 = '{hour: 5'h11, minute: {1'b0, r[4:0]} + 6'h1B, second: 6'h00};
    wr(OFS_TARGET_HOUR, {3'b000, t0.hour});
    wr(OFS_TARGET_MIN, {2'b00, t0.minute});
    rd(OFS_TARGET_MIN, {2'b00, t0.minute});
    settle(2);
    `CHK(irq, 1'b0, "irq idle")
    @(posedge core_clk);
    time_now <= t0;
    settle(5);
    `CHK(irq, 1'b1, "alarm irq")
    rd(OFS_IRQ_STATUS, 8'h01);
    wr(OFS_IRQ_ENABLE, 8'h02);
    settle(2);
    `CHK(irq, 1'b0, "alarm masked")
    wr(OFS_IRQ_CLEAR, 8'h01);
    rd(OFS_IRQ_STATUS, 8'h00);
    fire(1'b1, 1'b0, 1'b0);
    settle(3);
    `CHK(irq, 1'b1, "fail irq")
    rd(OFS_IRQ_STATUS, 8'h02);
    settle(2);
    summarize();
  end
endmodule : tb
